/* File: common/acmp_cfg.svh */
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH
// Register byte addresses; control registers keep their index, address is four times it
`define CMP0_CTRL_IDX      8'h00
`define CMP1_CTRL_IDX      8'h01
`define CMP0_CTRL_ADDR     12'h000
`define CMP1_CTRL_ADDR     12'h004
`define CMP0_SEL_ADDR      12'h008
`define CMP1_SEL_ADDR      12'h00C
`define OUT_CTRL_ADDR      12'h010
`define WIN_CTRL_ADDR      12'h014
`define STATUS_ADDR        12'h018
`define IRQ_MASK_ADDR      12'h01C
`define EVT_VECTOR_ADDR    12'h020
// Control register fields
`define CTRL_EN_BIT        0
`define CTRL_HYS_LSB       1
`define CTRL_LVL_LSB       4
`define CTRL_EDGE_LSB      6
// Selector fields
`define SEL_NEG_LSB        0
`define SEL_POS_LSB        3
// Window control fields
`define WIN_LVL_LSB        0
`define WIN_MODE_LSB       2
`define WIN_EN_BIT         4
// Status fields
`define ST_IF0_BIT         0
`define ST_IF1_BIT         1
`define ST_WIN_FLAG_BIT    2
`define ST_STATE0_BIT      4
`define ST_STATE1_BIT      5
`define ST_WSTATE_LSB      6
// Edge codes
`define EDGE_TOGGLE        2'h0
`define EDGE_FALL          2'h2
`define EDGE_RISE          2'h3
// Window codes
`define WIN_ABOVE          2'h0
`define WIN_INSIDE         2'h1
`define WIN_BELOW          2'h2
`define WIN_OUTSIDE        2'h3
// Input select codes
`define NEG_BANDGAP        3'h6
`define NEG_SCALER         3'h7
`define NEG_RESERVED       3'h5
`define POS_RESERVED       3'h7
`define REG_RESET          8'h00
`endif

/* File: common/acmp_pkg.sv */
package acmp_pkg;
   // Per-comparator control fields
   typedef struct packed {
      logic [1:0] edge_trigger_select;
      logic [1:0] irq_priority_level;
      logic       rsvd;
      logic [1:0] hysteresis_select;
      logic       enable;
   } comparator_control_t;

   // Input selector fields
   typedef struct packed {
      logic [1:0] rsvd;
      logic [2:0] positive_input_select;
      logic [2:0] negative_input_select;
   } comparator_input_select_t;

   // Analog core drive for one comparator
   typedef struct packed {
      logic       enable;
      logic [1:0] hysteresis_select;
      logic [2:0] positive_input_select;
      logic [2:0] negative_input_select;
   } analog_drive_t;

   // Bus data phase state
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ  = 2'b11
   } bus_state_t;
endpackage

/* File: hw/edge_unit.sv */
`include "acmp_cfg.svh"
module edge_unit (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   // Configuration
   input  wire logic       enable_i,
   input  wire logic [1:0] edge_trigger_select_i,
   // Comparator raw output
   input  wire logic       raw_i,
   // Results
   output logic            state_o,
   output logic            hit_o
);
   typedef struct packed {
      logic sync1_r;
      logic sync2_r;
      logic prev_r;
      logic armed_r;
      logic hit_r;
   } st_t;
   st_t st_r;
   st_t st_nxt;
   logic rise;
   logic fall;

   // Synchronise, then compare against last sampled level
   always_comb begin
      st_nxt         = st_r;
      st_nxt.sync1_r = raw_i;
      st_nxt.sync2_r = st_r.sync1_r;
      st_nxt.prev_r  = st_r.sync2_r;
      st_nxt.armed_r = enable_i;
      rise           = st_r.sync2_r & ~st_r.prev_r;
      fall           = ~st_r.sync2_r & st_r.prev_r;
      // Disabled or just-enabled: prev may be stale, so no edge
      if (!(enable_i && st_r.armed_r)) begin
         st_nxt.hit_r = 1'b0;
      end else begin
         case (edge_trigger_select_i)
            `EDGE_TOGGLE: st_nxt.hit_r = rise | fall;
            `EDGE_FALL:   st_nxt.hit_r = fall;
            `EDGE_RISE:   st_nxt.hit_r = rise;
            default:      st_nxt.hit_r = 1'b0; // Reserved code fires nothing
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign state_o = st_r.sync2_r & enable_i;
   assign hit_o   = st_r.hit_r;
endmodule // edge_unit

/* File: hw/acmp_pair.sv */
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "acmp_cfg.svh"
module acmp_pair (
   // Clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      resetn_i,
   // AHB-Lite slave
   input  wire logic                      hsel_i,
   input  wire logic [11:0]               haddr_i,
   input  wire logic [1:0]                htrans_i,
   input  wire logic                      hwrite_i,
   input  wire logic [2:0]                hsize_i,
   input  wire logic [31:0]               hwdata_i,
   input  wire logic                      hready_i,
   output logic      [31:0]               hrdata_o,
   output logic                           hreadyout_o,
   output logic                           hresp_o,
   // Analog cores: drive and raw outputs
   output acmp_pkg::analog_drive_t        core0_drive_o,
   output acmp_pkg::analog_drive_t        core1_drive_o,
   input  wire logic                      core0_raw_i,
   input  wire logic                      core1_raw_i,
   // Pin outputs of comparator state
   output logic                           cmp0_pin_o,
   output logic                           cmp0_pin_oe_o,
   output logic                           cmp1_pin_o,
   output logic                           cmp1_pin_oe_o,
   // Events and interrupts
   output logic                           cmp0_event_o,
   output logic                           cmp1_event_o,
   output logic                           window_event_o,
   input  wire logic [2:0]                vector_ack_i,
   output logic [1:0]                     cmp0_irq_level_o,
   output logic [1:0]                     cmp1_irq_level_o,
   output logic [1:0]                     window_irq_level_o,
   output logic                           irq_o
);
   typedef struct packed {
      acmp_pkg::comparator_control_t      ctrl0_r;
      acmp_pkg::comparator_control_t      ctrl1_r;
      acmp_pkg::comparator_input_select_t sel0_r;
      acmp_pkg::comparator_input_select_t sel1_r;
      logic [1:0]                         out_en_r;
      logic [4:0]                         win_r;
      logic [2:0]                         flags_r;
      logic [2:0]                         mask_r;
      logic [1:0]                         wstate_prev_r;
      logic                               win_armed_r;
      logic [2:0]                         event_r;
      acmp_pkg::bus_state_t               bus_r;
      logic [11:0]                        addr_r;
      logic [31:0]                        rdata_r;
   } st_t;
   st_t st_r;
   st_t st_nxt;

   logic       state0;
   logic       state1;
   logic       hit0;
   logic       hit1;
   logic [1:0] wstate;
   logic       win_en;
   logic       win_hit;
   logic [2:0] hits;
   logic [2:0] ena;
   logic [7:0] status_byte;
   logic [7:0] rd_byte;
   logic [2:0] w1c;

   // Reserved selector codes leave the input disconnected (drives off)
   function automatic logic sel_ok(input logic [2:0] pos, input logic [2:0] neg);
      sel_ok = (pos != `POS_RESERVED) && (neg != `NEG_RESERVED);
   endfunction

   // Reserved hysteresis code falls back to none
   function automatic logic [1:0] hys_map(input logic [1:0] h);
      hys_map = (h == 2'h3) ? 2'h0 : h;
   endfunction

   // Drive of one analog core from its registers
   function automatic acmp_pkg::analog_drive_t drive(
      input acmp_pkg::comparator_control_t      c,
      input acmp_pkg::comparator_input_select_t s);
      drive.enable                = c.enable &
                                    sel_ok(s.positive_input_select,
                                           s.negative_input_select);
      drive.hysteresis_select     = hys_map(c.hysteresis_select);
      drive.positive_input_select = s.positive_input_select;
      drive.negative_input_select = s.negative_input_select;
   endfunction

   // Core drives come straight from registers
   assign core0_drive_o = drive(st_r.ctrl0_r, st_r.sel0_r);
   assign core1_drive_o = drive(st_r.ctrl1_r, st_r.sel1_r);

   // Core raw output is high only for pos above neg; sync and edges here
   edge_unit u_edge0 (
      .mclk_i                (mclk_i),
      .resetn_i              (resetn_i),
      .enable_i              (core0_drive_o.enable),
      .edge_trigger_select_i (st_r.ctrl0_r.edge_trigger_select),
      .raw_i                 (core0_raw_i),
      .state_o               (state0),
      .hit_o                 (hit0)
   );
   edge_unit u_edge1 (
      .mclk_i                (mclk_i),
      .resetn_i              (resetn_i),
      .enable_i              (core1_drive_o.enable),
      .edge_trigger_select_i (st_r.ctrl1_r.edge_trigger_select),
      .raw_i                 (core1_raw_i),
      .state_o               (state1),
      .hit_o                 (hit1)
   );

   // Window position: comparator 0 high bound, comparator 1 low bound
   assign win_en = st_r.win_r[`WIN_EN_BIT] & core0_drive_o.enable
                   & core1_drive_o.enable;
   always_comb begin
      if (!win_en) begin
         wstate = `WIN_ABOVE;
      end else if (state0 && state1) begin
         wstate = `WIN_ABOVE;
      end else if (!state0 && state1) begin
         wstate = `WIN_INSIDE;
      end else if (!state0 && !state1) begin
         wstate = `WIN_BELOW;
      end else begin
         wstate = `WIN_OUTSIDE;
      end
   end

   // Window trigger on entering the selected region
   always_comb begin
      win_hit = 1'b0;
      if (win_en && st_r.win_armed_r && wstate != st_r.wstate_prev_r) begin
         case (st_r.win_r[`WIN_MODE_LSB +: 2])
            `WIN_ABOVE:   win_hit = (wstate == `WIN_ABOVE);
            `WIN_INSIDE:  win_hit = (wstate == `WIN_INSIDE);
            `WIN_BELOW:   win_hit = (wstate == `WIN_BELOW);
            `WIN_OUTSIDE: win_hit = (wstate != `WIN_INSIDE);
            default:      win_hit = 1'b0;
         endcase
      end
   end

   assign hits = {win_hit, hit1, hit0};
   assign ena  = {st_r.win_r[`WIN_LVL_LSB +: 2] != 2'h0,
                  st_r.ctrl1_r.irq_priority_level != 2'h0,
                  st_r.ctrl0_r.irq_priority_level != 2'h0};

   // Status byte as software sees it
   assign status_byte = {wstate, state1, state0, 1'b0, st_r.flags_r};

   // Read mux, unmapped addresses read zero
   always_comb begin
      case (haddr_i & 12'hFFC)
         `CMP0_CTRL_ADDR:  rd_byte = st_r.ctrl0_r;
         `CMP1_CTRL_ADDR:  rd_byte = st_r.ctrl1_r;
         `CMP0_SEL_ADDR:   rd_byte = st_r.sel0_r;
         `CMP1_SEL_ADDR:   rd_byte = st_r.sel1_r;
         `OUT_CTRL_ADDR:   rd_byte = {6'h00, st_r.out_en_r};
         `WIN_CTRL_ADDR:   rd_byte = {3'h0, st_r.win_r};
         `STATUS_ADDR:     rd_byte = status_byte;
         `IRQ_MASK_ADDR:   rd_byte = {5'h00, st_r.mask_r};
         `EVT_VECTOR_ADDR: rd_byte = {5'h00, st_r.event_r};
         default:          rd_byte = `REG_RESET;
      endcase
   end

   // Bus, registers, flags
   always_comb begin
      st_nxt             = st_r;
      w1c                = 3'h0;
      st_nxt.bus_r       = acmp_pkg::BUS_IDLE;
      st_nxt.event_r     = {win_hit, hit1, hit0};
      st_nxt.wstate_prev_r = wstate;
      st_nxt.win_armed_r = win_en;
      // Data phase of a write lands now
      if (st_r.bus_r == acmp_pkg::BUS_WRITE) begin
         case (st_r.addr_r)
            `CMP0_CTRL_ADDR: st_nxt.ctrl0_r = hwdata_i[7:0];
            `CMP1_CTRL_ADDR: st_nxt.ctrl1_r = hwdata_i[7:0];
            `CMP0_SEL_ADDR:  st_nxt.sel0_r  = {2'h0, hwdata_i[5:0]};
            `CMP1_SEL_ADDR:  st_nxt.sel1_r  = {2'h0, hwdata_i[5:0]};
            `OUT_CTRL_ADDR:  st_nxt.out_en_r = hwdata_i[1:0];
            `WIN_CTRL_ADDR:  st_nxt.win_r   = hwdata_i[4:0];
            `STATUS_ADDR:    w1c = hwdata_i[2:0];
            `IRQ_MASK_ADDR:  st_nxt.mask_r  = hwdata_i[2:0];
            default:         st_nxt.mask_r  = st_r.mask_r;
         endcase
         // Reserved control bit kept zero whatever software wrote
         st_nxt.ctrl0_r.rsvd = 1'b0;
         st_nxt.ctrl1_r.rsvd = 1'b0;
      end
      // Set beats clear; only enabled interrupts latch a flag
      st_nxt.flags_r = (st_r.flags_r & ~(w1c | vector_ack_i)) | (hits & ena);
      // Address phase capture; read data registered at once
      if (hsel_i && hready_i && htrans_i[1]) begin
         st_nxt.addr_r  = haddr_i & 12'hFFC;
         st_nxt.bus_r   = hwrite_i ? acmp_pkg::BUS_WRITE : acmp_pkg::BUS_READ;
         st_nxt.rdata_r = {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Bus answers: zero wait, always OKAY
   assign hrdata_o    = st_r.rdata_r;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   // Events and interrupt levels
   assign cmp0_event_o       = st_r.event_r[0];
   assign cmp1_event_o       = st_r.event_r[1];
   assign window_event_o     = st_r.event_r[2];
   assign cmp0_irq_level_o   = st_r.ctrl0_r.irq_priority_level;
   assign cmp1_irq_level_o   = st_r.ctrl1_r.irq_priority_level;
   assign window_irq_level_o = st_r.win_r[`WIN_LVL_LSB +: 2];
   assign irq_o              = |(st_r.flags_r & st_r.mask_r);

   // State to pins when routed
   assign cmp0_pin_o    = state0;
   assign cmp0_pin_oe_o = st_r.out_en_r[0];
   assign cmp1_pin_o    = state1;
   assign cmp1_pin_oe_o = st_r.out_en_r[1];
endmodule // acmp_pair

/* File: bench/acmp_pair_monitor.sv */
module acmp_pair_monitor (
   // Clock and reset
   input wire logic                    mclk_i,
   input wire logic                    resetn_i,
   // Watched design ports
   input wire logic                    hreadyout_o,
   input wire logic                    hresp_o,
   input wire acmp_pkg::analog_drive_t core0_drive_o,
   input wire acmp_pkg::analog_drive_t core1_drive_o,
   input wire logic                    core0_raw_i,
   input wire logic                    cmp0_pin_o,
   input wire logic                    cmp0_event_o,
   input wire logic                    window_event_o,
   input wire logic                    irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   // Zero-wait slave, always OKAY
   AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o) else $error("bus stall");
   // Reserved selector codes never power core 0
   AST_SEL_RSVD: assert property (core0_drive_o.enable |->
      3'h7 != core0_drive_o.positive_input_select
      && 3'h5 != core0_drive_o.negative_input_select) else $error("reserved select on");
   // Reserved hysteresis never reaches a core
   AST_HYS_LEGAL: assert property (core0_drive_o.hysteresis_select != 2'h3
      && core1_drive_o.hysteresis_select != 2'h3) else $error("reserved hysteresis");
   // Event four edges after the raw change that caused it
   AST_EVT_CAUSE: assert property (cmp0_event_o |->
      $past(core0_raw_i, 4) != $past(core0_raw_i, 5)) else $error("event without edge");
   // One transition gives one pulse
   AST_EVT_SINGLE: assert property (cmp0_event_o |=> !cmp0_event_o) else $error("long event");
   // Quiet while switched off
   AST_EVT_OFF: assert property ((!core0_drive_o.enable)[*6] |-> !cmp0_event_o)
      else $error("event while off");
   // Pin mirrors the synchronised result
   AST_PIN_STATE: assert property (core0_drive_o.enable && $past(core0_drive_o.enable, 3)
      |-> cmp0_pin_o == $past(core0_raw_i, 2)) else $error("pin state");
   // Window needs both comparators running
   AST_WIN_BOTH: assert property (window_event_o |->
      $past(core0_drive_o.enable) && $past(core1_drive_o.enable)) else $error("window off");
   // Main scenarios reached
   cover property (cmp0_event_o);
   cover property (window_event_o);
   cover property ($rose(irq_o));
endmodule // acmp_pair_monitor

bind acmp_pair acmp_pair_monitor mon_u (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .core0_drive_o(core0_drive_o), .core1_drive_o(core1_drive_o), .core0_raw_i(core0_raw_i),
   .cmp0_pin_o(cmp0_pin_o), .cmp0_event_o(cmp0_event_o), .window_event_o(window_event_o),
   .irq_o(irq_o));

/* File: bench/acmp_core_model.sv */
module acmp_core_model (
   // Core drive from the block
   input  wire acmp_pkg::analog_drive_t drive_i,
   // Pins 0..7, bandgap at 8, scaler at 9
   input  wire logic [7:0]              level_i [0:9],
   // Raw comparator result
   output logic                         raw_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] s;
   logic [3:0] n;
   // Negative map skips even pins above 1
   assign s = {1'b0, drive_i.negative_input_select};
   assign n = (s < 4'h2) ? s : (s < 4'h5) ? 4'(2 * s - 1) : 4'(s + 2);
   initial raw_o = 1'b0;
   // One only when positive is above negative
   always @* begin
      if (drive_i.enable === 1'b1) begin
         raw_o = level_i[drive_i.positive_input_select] > level_i[n];
      end
   end
   // Switched-off core gives no clean level
   always @(negedge drive_i.enable) begin
      raw_o = ~raw_o;
   end
endmodule // acmp_core_model

/* File: bench/acmp_pair_tb.sv */
`include "acmp_cfg.svh"
module acmp_pair_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    mclk_i, resetn_i, hwrite_i, hreadyout_o, hresp_o;
   logic                    raw0, raw1, pin0, oe0, ev0, evw, irq, f;
   logic                    pin1, oe1, ev1;
   logic [11:0]             haddr_i;
   logic [1:0]              htrans_i, lvl0, lvl1, wl;
   logic [2:0]              ack;
   logic [31:0]             hwdata_i, hrdata_o, q;
   logic [7:0]              c0, c1, s0, s1;
   logic [7:0]              lv [0:9];
   acmp_pkg::analog_drive_t drv0, drv1;
   int                      err_count, compares, b, b1, n0, n1, nw;
   logic [11:0] ra [10] = '{`CMP0_CTRL_ADDR, `CMP1_CTRL_ADDR, `CMP0_SEL_ADDR, `CMP1_SEL_ADDR,
      `OUT_CTRL_ADDR, `WIN_CTRL_ADDR, `STATUS_ADDR, `IRQ_MASK_ADDR, `EVT_VECTOR_ADDR, 12'h0fc};
   logic [1:0]  md [3] = '{`EDGE_TOGGLE, `EDGE_FALL, `EDGE_RISE};
   logic [1:0]  ws [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
   logic [7:0]  st [4] = '{8'h78, 8'h28, 8'h78, 8'h78};
   logic [7:0]  tg [4] = '{8'hc8, 8'h78, 8'h28, 8'hc8};

   acmp_pair dut_u (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(1'b1), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .core0_drive_o(drv0), .core1_drive_o(drv1), .core0_raw_i(raw0), .core1_raw_i(raw1),
      .cmp0_pin_o(pin0), .cmp0_pin_oe_o(oe0), .cmp1_pin_o(pin1), .cmp1_pin_oe_o(oe1),
      .cmp0_event_o(ev0), .cmp1_event_o(ev1), .window_event_o(evw), .vector_ack_i(ack),
      .cmp0_irq_level_o(lvl0), .cmp1_irq_level_o(lvl1), .window_irq_level_o(wl), .irq_o(irq));
   acmp_core_model m0_u (.drive_i(drv0), .level_i(lv), .raw_o(raw0));
   acmp_core_model m1_u (.drive_i(drv1), .level_i(lv), .raw_o(raw1));

   // Clock and hang guard
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   initial begin
      #200_000;
      err_count++;
      stop_test();
   end
   // Event tallies; read just after an edge they hold the count so far
   always @(posedge mclk_i) begin
      n0 <= n0 + int'(ev0 === 1'b1);
      n1 <= n1 + int'(ev1 === 1'b1);
      nw <= nw + int'(evw === 1'b1);
   end

   task automatic stop_test();
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   // Single transfer; address held until hready, data until hready again
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      htrans_i <= 2'h2;
      haddr_i  <= a;
      hwrite_i <= wr;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   // Core drive expected from control and selector bytes
   function automatic acmp_pkg::analog_drive_t exp_drv(input logic [7:0] c, input logic [7:0] s);
      exp_drv.enable = c[0] && s[5:3] != 3'h7 && s[2:0] != 3'h5;
      exp_drv.hysteresis_select = (c[2:1] == 2'h3) ? 2'h0 : c[2:1];
      exp_drv.positive_input_select = s[5:3];
      exp_drv.negative_input_select = s[2:0];
   endfunction

   initial begin
      {resetn_i, hwrite_i, htrans_i, haddr_i, hwdata_i, ack, n0, n1, nw} = '0;
      lv = '{default: 8'h64};
      void'($urandom(32'h1c07_8331));
      repeat (10) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      foreach (ra[i]) rdc(ra[i], 32'hffff_ffff, 32'h0);
      // Random settings; selector before control, reserved bits zero
      repeat (8) begin
         {c0, c1, s0, s1} = $urandom & 32'hf7f7_3f3f;
         bus(1'b1, `CMP0_SEL_ADDR, s0);
         bus(1'b1, `CMP1_SEL_ADDR, s1);
         bus(1'b1, `CMP0_CTRL_ADDR, c0);
         bus(1'b1, `CMP1_CTRL_ADDR, c1);
         rdc(`CMP1_CTRL_ADDR, 32'hffff_ffff, c1);
         rdc(`CMP0_SEL_ADDR, 32'hffff_ffff, s0);
         chk(32'(drv0), 32'(exp_drv(c0, s0)));
         chk(32'(drv1), 32'(exp_drv(c1, s1)));
         chk({lvl1, lvl0}, {c1[5:4], c0[5:4]});
      end
      bus(1'b1, `CMP1_CTRL_ADDR, 8'h00);
      bus(1'b1, `CMP0_SEL_ADDR, 8'h01);
      bus(1'b1, `OUT_CTRL_ADDR, 8'h01);
      bus(1'b1, `IRQ_MASK_ADDR, 8'h07);
      // Each edge code, level 0 on toggle so events run without a flag
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, `CMP0_CTRL_ADDR, {md[m], 2'(m), 4'h1});
         repeat (8) @(posedge mclk_i);
         bus(1'b1, `STATUS_ADDR, 8'h07);
         for (int d = 1; d >= 0; d--) begin
            b = n0;
            lv[0] <= d[0] ? 8'hc8 : 8'h0a;
            repeat (8) @(posedge mclk_i);
            f = md[m] == `EDGE_TOGGLE || md[m][0] == d[0];
            chk(n0 - b, f);
            chk({oe0, pin0, irq}, {1'b1, d[0], f && m != 0});
            rdc(`STATUS_ADDR, 32'h17, {d[0], 3'h0, f && m != 0});
            if (m == 1) begin
               ack <= 3'h1;
               @(posedge mclk_i);
               ack <= 3'h0;
            end else begin
               bus(1'b1, `IRQ_MASK_ADDR, 8'h00);
               repeat (2) @(posedge mclk_i);
               chk(irq, 1'b0);
               bus(1'b1, `STATUS_ADDR, 8'h01);
               bus(1'b1, `IRQ_MASK_ADDR, 8'h07);
            end
            repeat (2) @(posedge mclk_i);
            rdc(`STATUS_ADDR, 32'h07, 32'h0);
            chk(irq, 1'b0);
         end
      end
      // Window: comparator 0 high bound, comparator 1 low bound
      lv[1] <= 8'h50;
      lv[3] <= 8'ha0;
      bus(1'b1, `CMP0_SEL_ADDR, 8'h12);
      bus(1'b1, `CMP1_SEL_ADDR, 8'h11);
      bus(1'b1, `CMP0_CTRL_ADDR, 8'h01);
      bus(1'b1, `CMP1_CTRL_ADDR, 8'h01);
      for (int w = 0; w < 4; w++) begin
         lv[2] <= st[w];
         bus(1'b1, `WIN_CTRL_ADDR, 8'h11 | 8'(w << 2));
         repeat (8) @(posedge mclk_i);
         bus(1'b1, `STATUS_ADDR, 8'h07);
         b = nw;
         b1 = n1;
         lv[2] <= tg[w];
         repeat (10) @(posedge mclk_i);
         chk(nw - b, 1);
         chk(n1 - b1, w == 1 || w == 2);
         chk({oe1, pin1, wl}, {1'b0, tg[w] > 8'h50, 2'h1});
         chk(irq, 1'b1);
         rdc(`STATUS_ADDR, 32'hc4, {ws[w], 6'h04});
      end
      // Window off and comparator 0 off: random levels give nothing
      bus(1'b1, `CMP0_CTRL_ADDR, 8'h00);
      bus(1'b1, `WIN_CTRL_ADDR, 8'h01);
      repeat (8) @(posedge mclk_i);
      b = nw + n0;
      repeat (6) begin
         lv[0] <= 8'($urandom);
         lv[2] <= 8'($urandom);
         repeat (8) @(posedge mclk_i);
      end
      chk(nw + n0 - b, 0);
      stop_test();
   end
endmodule // acmp_pair_tb
